// *** hdl/pus_scaler.sv ***
`timescale 1ns/10ps
// What this block does
// - scaling setting 0..32, resets to 20
// - 64-bit position reduced to 32-bit fieldbus word
// - fieldbus word gives 2^setting counts per turn
// - low word angle, high word signed turns
// - same reduction for position and following error
// - output gear unsigned 32-bit, resets to 20
// - user unit from input over output gear
// - unit selector 0 raw counts, 3 geared
// - input gear unsigned, resets to 100
module pus_scaler (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // parameter port
  input  wire logic        par_wr_en,
  input  wire logic        par_rd_en,
  input  wire logic [15:0] par_addr,
  input  wire logic [31:0] par_wdata,
  output logic      [31:0] par_rdata,
  output logic             par_rd_ok,
  output logic             par_rd_err,
  // internal position sample
  input  wire logic        pos_valid,
  input  wire logic [63:0] actual_pos,
  input  wire logic [63:0] follow_err,
  // fieldbus process words
  output logic             fb_valid,
  output logic      [31:0] fb_actual_pos,
  output logic      [31:0] fb_follow_err,
  // user unit position, 32.32
  output logic             user_valid,
  output logic      [63:0] user_pos,
  output logic             user_div_zero
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  fb_shift_ff;      // scaling setting
  logic [31:0] unit_sel_ff;      // position unit selector
  logic [31:0] out_gear_ff;      // output gear
  logic [31:0] in_gear_ff;       // input gear
  logic [31:0] par_rdata_ff;     // read answer
  logic        par_rd_ok_ff;     // read hit
  logic        par_rd_err_ff;    // read miss
  logic        fb_valid_ff;      // fieldbus words fresh
  logic [31:0] fb_pos_ff;        // scaled actual position
  logic [31:0] fb_err_ff;        // scaled following error
  logic        user_valid_ff;    // user position fresh
  logic [63:0] user_pos_ff;      // user position
  logic        div_zero_ff;      // geared request with zero output gear
  pus_pkg::pus_div_st_t div_st_ff; // divider state
  logic [6:0]  div_cnt_ff;       // steps left
  logic [95:0] div_q_ff;         // dividend shifting into quotient
  logic [32:0] div_rem_ff;       // partial remainder
  logic [31:0] div_den_ff;       // latched output gear
  logic        div_neg_ff;       // sign of the sample

  // ****************************************************************
  // helpers
  // ****************************************************************
  // angle width as a sized shift base, declared before the function reads it
  localparam logic [6:0] ANGLE_BITS_C = 7'(pus_pkg::ANGLE_BITS);
  // reduce 64-bit 32.32 position to the fieldbus word
  function automatic logic [31:0] fb_scale(input logic [63:0] pos, input logic [7:0] sh);
    logic [63:0] shifted;
    shifted = pos >> (6'(ANGLE_BITS_C) - sh[5:0]);
    return shifted[31:0];
  endfunction

  // write strobe decode
  logic wr_shift;
  logic wr_unit;
  logic shift_ok;
  logic unit_ok;
  logic div_start;
  assign wr_shift  = par_wr_en && (par_addr == pus_pkg::OFS_FB_SHIFT);
  assign wr_unit   = par_wr_en && (par_addr == pus_pkg::OFS_UNIT_SEL);
  assign shift_ok  = (par_wdata <= pus_pkg::MAX_FB_SHIFT);
  assign unit_ok   = (par_wdata == pus_pkg::UNIT_COUNTS) || (par_wdata == pus_pkg::UNIT_GEARED);
  // geared conversion starts only when idle and divisor is usable
  assign div_start = pos_valid && (unit_sel_ff == pus_pkg::UNIT_GEARED) && (div_st_ff == pus_pkg::DIV_IDLE)
                     && (out_gear_ff != 32'h0000_0000);

  // ****************************************************************
  // parameter registers
  // ****************************************************************
  // scaling setting, illegal values leave it unchanged
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fb_shift_ff <= pus_pkg::RST_FB_SHIFT;
    end else if (wr_shift && shift_ok) begin
      fb_shift_ff <= par_wdata[7:0];
    end
  end

  // unit selector, only 0 or 3 accepted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unit_sel_ff <= pus_pkg::RST_UNIT_SEL;
    end else if (wr_unit && unit_ok) begin
      unit_sel_ff <= par_wdata;
    end
  end

  // gear pair, full unsigned range
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_gear_ff <= pus_pkg::RST_OUT_GEAR;
      in_gear_ff  <= pus_pkg::RST_IN_GEAR;
    end else if (par_wr_en) begin
      if (par_addr == pus_pkg::OFS_OUT_GEAR) begin
        out_gear_ff <= par_wdata;
      end
      if (par_addr == pus_pkg::OFS_IN_GEAR) begin
        in_gear_ff <= par_wdata;
      end
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      par_rdata_ff  <= 32'h0000_0000;
      par_rd_ok_ff  <= 1'b0;
      par_rd_err_ff <= 1'b0;
    end else begin
      par_rd_ok_ff  <= par_rd_en;
      par_rd_err_ff <= 1'b0;
      par_rdata_ff  <= 32'h0000_0000;
      if (par_rd_en) begin
        case (par_addr)
          pus_pkg::OFS_FB_SHIFT: par_rdata_ff <= {24'h00_0000, fb_shift_ff};
          pus_pkg::OFS_UNIT_SEL: par_rdata_ff <= unit_sel_ff;
          pus_pkg::OFS_OUT_GEAR: par_rdata_ff <= out_gear_ff;
          pus_pkg::OFS_IN_GEAR:  par_rdata_ff <= in_gear_ff;
          default: begin
            // unmapped: zero data, error flag
            par_rd_ok_ff  <= 1'b0;
            par_rd_err_ff <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // fieldbus reduction
  // ****************************************************************
  // both process words use the same shift
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fb_valid_ff <= 1'b0;
      fb_pos_ff   <= 32'h0000_0000;
      fb_err_ff   <= 32'h0000_0000;
    end else begin
      fb_valid_ff <= pos_valid;
      if (pos_valid) begin
        fb_pos_ff <= fb_scale(actual_pos, fb_shift_ff);
        fb_err_ff <= fb_scale(follow_err, fb_shift_ff);
      end
    end
  end

  // ****************************************************************
  // user unit conversion
  // ****************************************************************
  // magnitude of the signed turn count with angle
  logic [63:0] pos_mag;
  logic [95:0] prod;
  logic [32:0] rem_sh;
  logic        q_bit;
  logic [32:0] nxt_rem;
  logic [95:0] nxt_q;
  assign pos_mag = actual_pos[63] ? (64'h0 - actual_pos) : actual_pos;
  assign prod    = {32'h0000_0000, pos_mag} * {64'h0, in_gear_ff};
  assign rem_sh  = {div_rem_ff[31:0], div_q_ff[95]};
  assign q_bit   = rem_sh >= {1'b0, div_den_ff};
  assign nxt_rem = q_bit ? (rem_sh - {1'b0, div_den_ff}) : rem_sh;
  assign nxt_q   = {div_q_ff[94:0], q_bit};

  // restoring divider, one bit per cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_st_ff  <= pus_pkg::DIV_IDLE;
      div_cnt_ff <= 7'h00;
      div_q_ff   <= 96'h0;
      div_rem_ff <= 33'h0;
      div_den_ff <= 32'h0000_0000;
      div_neg_ff <= 1'b0;
    end else begin
      case (div_st_ff)
        pus_pkg::DIV_IDLE: begin
          if (div_start) begin
            div_st_ff  <= pus_pkg::DIV_RUN;
            div_cnt_ff <= pus_pkg::DIV_STEPS;
            div_q_ff   <= prod;
            div_rem_ff <= 33'h0;
            div_den_ff <= out_gear_ff;
            div_neg_ff <= actual_pos[63];
          end
        end
        pus_pkg::DIV_RUN: begin
          div_q_ff   <= nxt_q;
          div_rem_ff <= nxt_rem;
          div_cnt_ff <= div_cnt_ff - 7'h01;
          if (div_cnt_ff == 7'h01) begin
            div_st_ff <= pus_pkg::DIV_IDLE;
          end
        end
        default: div_st_ff <= pus_pkg::DIV_IDLE;
      endcase
    end
  end

  // user position: raw counts directly, geared from the divider
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      user_valid_ff <= 1'b0;
      user_pos_ff   <= 64'h0;
      div_zero_ff   <= 1'b0;
    end else begin
      user_valid_ff <= 1'b0;
      div_zero_ff   <= 1'b0;
      if (pos_valid && (unit_sel_ff == pus_pkg::UNIT_COUNTS) && (div_st_ff == pus_pkg::DIV_IDLE)) begin
        user_valid_ff <= 1'b1;
        user_pos_ff   <= actual_pos;
      end else if (div_st_ff == pus_pkg::DIV_RUN && div_cnt_ff == 7'h01) begin
        user_valid_ff <= 1'b1;
        user_pos_ff   <= div_neg_ff ? (64'h0 - nxt_q[63:0]) : nxt_q[63:0];
      end else if (pos_valid && (unit_sel_ff == pus_pkg::UNIT_GEARED) && (div_st_ff == pus_pkg::DIV_IDLE)
                   && (out_gear_ff == 32'h0000_0000)) begin
        div_zero_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign par_rdata     = par_rdata_ff;
  assign par_rd_ok     = par_rd_ok_ff;
  assign par_rd_err    = par_rd_err_ff;
  assign fb_valid      = fb_valid_ff;
  assign fb_actual_pos = fb_pos_ff;
  assign fb_follow_err = fb_err_ff;
  assign user_valid    = user_valid_ff;
  assign user_pos      = user_pos_ff;
  assign user_div_zero = div_zero_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_shift_range: assert property (fb_shift_ff <= 8'h20)
    else $error("scaling setting out of range");
  a_shift_reset: assert property ($past(sys_rst) |-> fb_shift_ff == 8'h14 && out_gear_ff == 32'h14
    && in_gear_ff == 32'h64) else $error("reset values wrong");
  a_bad_shift_kept: assert property (wr_shift && !shift_ok |=> $stable(fb_shift_ff))
    else $error("illegal scaling write took effect");
  a_good_shift_load: assert property (wr_shift && shift_ok |=> fb_shift_ff == $past(par_wdata[7:0]))
    else $error("legal scaling write lost");
  a_unit_legal: assert property (unit_sel_ff == 32'h0 || unit_sel_ff == 32'h3)
    else $error("unit selector illegal");
  a_fb_pos_scaled: assert property (pos_valid |=> fb_valid &&
    fb_actual_pos == 32'(64'($past(actual_pos)) >> (7'h20 - 7'($past(fb_shift_ff)))))
    else $error("fieldbus position wrong");
  a_fb_err_scaled: assert property (pos_valid |=>
    fb_follow_err == 32'(64'($past(follow_err)) >> (7'h20 - 7'($past(fb_shift_ff)))))
    else $error("following error wrong");
  a_raw_unit: assert property (pos_valid && unit_sel_ff == 32'h0 && div_st_ff == pus_pkg::DIV_IDLE
    |=> user_valid && user_pos == $past(actual_pos)) else $error("raw position wrong");
  a_div_timing: assert property (div_start |-> ##97 user_valid)
    else $error("geared result late");
  a_div_quiet: assert property (div_start |=> !user_valid [*8])
    else $error("geared result early");

  c_geared_done: cover property (div_start ##97 user_valid);
  c_bad_write: cover property (wr_shift && !shift_ok);
  c_full_shift: cover property (pos_valid && fb_shift_ff == 8'h20);
  c_zero_gear: cover property (user_div_zero);

endmodule

// *** hdl/pus_pkg.sv ***
// ****************************************************************
// position unit scaler constants
// ****************************************************************
package pus_pkg;
  // register offsets on the parameter port
  localparam logic [15:0] OFS_FB_SHIFT  = 16'h0130;
  localparam logic [15:0] OFS_UNIT_SEL  = 16'h0658;
  localparam logic [15:0] OFS_OUT_GEAR  = 16'h0660;
  localparam logic [15:0] OFS_IN_GEAR   = 16'h0664;
  // reset values
  localparam logic [7:0]  RST_FB_SHIFT  = 8'h14;
  localparam logic [31:0] RST_UNIT_SEL  = 32'h0000_0000;
  localparam logic [31:0] RST_OUT_GEAR  = 32'h0000_0014;
  localparam logic [31:0] RST_IN_GEAR   = 32'h0000_0064;
  // limits and encodings
  localparam logic [31:0] MAX_FB_SHIFT  = 32'h0000_0020;
  localparam logic [31:0] UNIT_COUNTS   = 32'h0000_0000;
  localparam logic [31:0] UNIT_GEARED   = 32'h0000_0003;
  // position layout: high word turns, low word angle
  localparam int          ANGLE_BITS    = 32;
  // serial divider: one quotient bit per cycle over the 96-bit product
  localparam logic [6:0]  DIV_STEPS     = 7'h60;
  // divider states
  typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} pus_div_st_t;
endpackage

// *** sim/pus_fb_master.sv ***
`timescale 1ns/10ps
// ****************************************************************
// fieldbus master model: latches scaled process words per frame
// ****************************************************************
module pus_fb_master (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // process words from the drive
  input  wire logic        fb_valid,
  input  wire logic [31:0] fb_actual_pos,
  input  wire logic [31:0] fb_follow_err,
  // latched copies for the bench
  output logic      [31:0] got_pos_ff,
  output logic      [31:0] got_err_ff,
  output logic      [15:0] frames_ff
);
  // both words of one frame are taken on the same edge, never mixed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      got_pos_ff <= 32'h0000_0000;
      got_err_ff <= 32'h0000_0000;
      frames_ff  <= 16'h0000;
    end else if (fb_valid) begin
      got_pos_ff <= fb_actual_pos;
      got_err_ff <= fb_follow_err;
      frames_ff  <= frames_ff + 16'h0001;
    end
  end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
// ****************************************************************
// bench for the position unit scaler
// ****************************************************************
module tb_top;
  logic        clk = 1'b0;        // 25 MHz clock
  logic        sys_rst = 1'b1;    // held high at start
  logic        par_wr_en = 1'b0;  // write strobe
  logic        par_rd_en = 1'b0;  // read strobe
  logic [15:0] par_addr = 16'h0000;
  logic [31:0] par_wdata = 32'h0000_0000;
  logic [31:0] par_rdata;
  logic        par_rd_ok, par_rd_err;
  logic        pos_valid = 1'b0;  // sample strobe
  logic [63:0] actual_pos = 64'h0, follow_err = 64'h0;
  logic        fb_valid, user_valid, user_div_zero;
  logic [31:0] fb_actual_pos, fb_follow_err, got_pos, got_err;
  logic [63:0] user_pos, ep, ee;
  logic [15:0] frames;
  int          miscompares = 0, cmp_count = 0;
  int          shifts [4] = '{20, 16, 0, 32};
  localparam logic [63:0] P0 = 64'h0000_0023_1234_abcd; // sample position
  localparam logic [63:0] E0 = 64'hffff_fffe_8765_4321; // negative error
  always #20 clk = ~clk;
  pus_scaler dut (.clk(clk), .sys_rst(sys_rst), .par_wr_en(par_wr_en), .par_rd_en(par_rd_en),
    .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rd_ok(par_rd_ok),
    .par_rd_err(par_rd_err), .pos_valid(pos_valid), .actual_pos(actual_pos), .follow_err(follow_err),
    .fb_valid(fb_valid), .fb_actual_pos(fb_actual_pos), .fb_follow_err(fb_follow_err),
    .user_valid(user_valid), .user_pos(user_pos), .user_div_zero(user_div_zero));
  pus_fb_master master (.clk(clk), .sys_rst(sys_rst), .fb_valid(fb_valid), .fb_actual_pos(fb_actual_pos),
    .fb_follow_err(fb_follow_err), .got_pos_ff(got_pos), .got_err_ff(got_err), .frames_ff(frames));
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write on the parameter port
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    par_wr_en = 1'b1;
    par_addr  = a;
    par_wdata = d;
    @(negedge clk);
    par_wr_en = 1'b0;
  endtask
  // one-cycle read, answer checked the cycle after
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic err);
    @(negedge clk);
    par_rd_en = 1'b1;
    par_addr  = a;
    @(negedge clk);
    par_rd_en = 1'b0;
    chk("par_rdata", par_rdata, exp);
    chk("par_rd_err", par_rd_err, err);
    chk("par_rd_ok", par_rd_ok, !err);
  endtask
  // one position sample, left on the negedge after the posedge that registers the results
  task automatic smp(input logic [63:0] p, input logic [63:0] e);
    @(negedge clk);
    pos_valid  = 1'b1;
    actual_pos = p;
    follow_err = e;
    @(negedge clk);
    pos_valid  = 1'b0;
  endtask
  // bounded wait for a user position result, a timeout counts as a mismatch
  task automatic wait_user();
    int k;
    k = 0;
    while (user_valid !== 1'b1 && k <= 120) begin
      k++;
      @(negedge clk);
    end
    if (k > 120) begin
      miscompares++;
    end
  endtask
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    rd(16'h0130, 32'h0000_0014, 1'b0);
    rd(16'h0658, 32'h0000_0000, 1'b0);
    rd(16'h0660, 32'h0000_0014, 1'b0);
    rd(16'h0664, 32'h0000_0064, 1'b0);
    rd(16'h0100, 32'h0000_0000, 1'b1);
    // reduction at the documented and the boundary shift settings
    foreach (shifts[i]) begin
      if (shifts[i] != 20) begin
        wr(16'h0130, shifts[i]);
      end
      smp(P0, E0);
      ep = P0 >> (32 - shifts[i]);
      ee = E0 >> (32 - shifts[i]);
      chk("fb_valid", fb_valid, 1'b1);
      chk("fb_actual_pos", fb_actual_pos, ep[31:0]);
      chk("fb_follow_err", fb_follow_err, ee[31:0]);
      chk("user_valid", user_valid, 1'b1);
      chk("user_pos counts", user_pos, P0);
      @(negedge clk);
      chk("master pos", got_pos, ep[31:0]);
      chk("master err", got_err, ee[31:0]);
    end
    chk("frames", frames, 16'h0004);
    wr(16'h0130, 32'h0000_0021);
    rd(16'h0130, 32'h0000_0020, 1'b0);
    wr(16'h0658, 32'h0000_0002);
    rd(16'h0658, 32'h0000_0000, 1'b0);
    wr(16'h0658, 32'h0000_0003);
    rd(16'h0658, 32'h0000_0003, 1'b0);
    // geared unit: in 100 over out 20
    smp(P0, E0);
    wait_user();
    chk("user_pos geared", user_pos, (P0 * 64'h64) / 64'h14);
    wr(16'h0660, 32'h0000_0000);
    rd(16'h0660, 32'h0000_0000, 1'b0);
    smp(P0, E0);
    chk("user_div_zero", user_div_zero, 1'b1);
    chk("user_valid gear 0", user_valid, 1'b0);
    // written gear pair with negative turns: in 7 over out 2, truncated toward zero
    wr(16'h0664, 32'h0000_0007);
    rd(16'h0664, 32'h0000_0007, 1'b0);
    wr(16'h0660, 32'h0000_0002);
    smp(E0, P0);
    wait_user();
    chk("user_pos negative geared", user_pos, $signed(E0) * 64'sh7 / 64'sh2);
    close_out();
  end
endmodule
